// ===== rtl/spmc_top.sv
// Serial port mode control: registers, transmitter, shift mode, flags
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`default_nettype none
module spmc_top
  import spmc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Serial pins
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n
);
  logic rst_meta_q;
  logic rst_n_q;
  // Register contents
  logic sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q;
  logic baud_double_select_q, frame_error_select_q;
  logic [7:0] slave_address_q;
  logic [7:0] smask_q;
  logic [7:0] rx_data_q;
  logic [15:0] baud_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  // Bus
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic wr_lo;
  logic [7:0] wbyte;
  logic [31:0] rdata_d;
  // Engines
  logic [1:0] mode;
  logic [15:0] bit_cycles;
  spmc_tx_state_t tx_state_q;
  logic [15:0] tcnt_q;
  logic [3:0] tbit_q;
  logic [8:0] tsh_q;
  logic sh_rx_q;
  logic tcnt_zero;
  logic tx_evt, rx_evt, fe_evt, m0_rx_evt;
  logic rx_done, rx_ninth, rx_stop;
  logic [7:0] rx_byte;
  logic rx_accept;
  logic [7:0] m0_byte;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  assign mode = {sm0_q, sm1_q};
  always_comb
  begin
    unique case (mode)
      SPMC_MODE_SHIFT: bit_cycles = SPMC_CYC_MODE0;
      SPMC_MODE_UART9_FIXED: bit_cycles = baud_double_select_q ? SPMC_CYC_MODE2_FAST : SPMC_CYC_MODE2_SLOW;
      default: bit_cycles = baud_q + 16'h0001;
    endcase
  end

  // Access happens at the edge that sees waitrequest low
  assign req = avs_read | avs_write;
  assign acc = req & ~avs_waitrequest;
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;
  assign wr_lo = wr_acc & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address)
      SPMC_OFS_CTRL: rdata_d[7:0] = {frame_error_select_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q,
                                     tb8_q, rb8_q, ti_q, ri_q};
      SPMC_OFS_CFG:
      begin
        rdata_d[SPMC_B_BAUD_DOUBLE_SELECT] = baud_double_select_q;
        rdata_d[SPMC_B_FRAME_ERROR_SELECT] = frame_error_select_q;
        rdata_d[SPMC_B_TX_BUSY] = (tx_state_q != TX_IDLE);
      end
      SPMC_OFS_SLAVE_ADDRESS: rdata_d[7:0] = slave_address_q;
      SPMC_OFS_SMASK: rdata_d[7:0] = smask_q;
      SPMC_OFS_DATA: rdata_d[7:0] = rx_data_q;
      SPMC_OFS_BAUD: rdata_d[15:0] = baud_q;
      SPMC_OFS_IRQ_STAT: rdata_d[2:0] = irq_stat_q;
      SPMC_OFS_IRQ_MASK: rdata_d[2:0] = irq_mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // One wait cycle, then one ready cycle per access
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest)
        avs_readdata <= rdata_d;
    end
  end

  // Software configuration
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sm0_q <= 1'b0;
      sm1_q <= 1'b0;
      sm2_q <= 1'b0;
      ren_q <= 1'b0;
      tb8_q <= 1'b0;
      baud_double_select_q <= 1'b0;
      frame_error_select_q <= 1'b0;
      slave_address_q <= SPMC_RST_BYTE;
      smask_q <= SPMC_RST_BYTE;
      baud_q <= SPMC_RST_BAUD;
      irq_mask_q <= 3'h0;
    end
    else
    begin
      if (wr_lo && avs_address == SPMC_OFS_CTRL)
      begin
        if (!frame_error_select_q)
          sm0_q <= wbyte[SPMC_B_SM0_FE];
        sm1_q <= wbyte[SPMC_B_SM1];
        sm2_q <= wbyte[SPMC_B_SM2];
        ren_q <= wbyte[SPMC_B_REN];
        tb8_q <= wbyte[SPMC_B_TB8];
      end
      if (wr_lo && avs_address == SPMC_OFS_CFG)
      begin
        baud_double_select_q <= wbyte[SPMC_B_BAUD_DOUBLE_SELECT];
        frame_error_select_q <= wbyte[SPMC_B_FRAME_ERROR_SELECT];
      end
      if (wr_lo && avs_address == SPMC_OFS_SLAVE_ADDRESS)
        slave_address_q <= wbyte;
      if (wr_lo && avs_address == SPMC_OFS_SMASK)
        smask_q <= wbyte;
      if (wr_lo && avs_address == SPMC_OFS_IRQ_MASK)
        irq_mask_q <= wbyte[2:0];
      if (wr_lo && avs_address == SPMC_OFS_BAUD)
        baud_q[7:0] <= wbyte;
      if (wr_acc && avs_byteenable[1] && avs_address == SPMC_OFS_BAUD)
        baud_q[15:8] <= avs_writedata[15:8];
    end
  end

  // Async receiver runs only outside shift mode
  spmc_rx u_rx (
    .clk(sys_clk),
    .rst_n(rst_n_q),
    .enable(ren_q && mode != SPMC_MODE_SHIFT),
    .ninth_en(sm0_q),
    .bit_cycles(bit_cycles),
    .rxd(rxd_in),
    .done(rx_done),
    .data(rx_byte),
    .ninth(rx_ninth),
    .stop_bit(rx_stop)
  );

  // Address filtering in the asynchronous modes
  always_comb
  begin
    if (!sm2_q)
      rx_accept = 1'b1;
    else if (mode == SPMC_MODE_UART8)
      rx_accept = rx_stop && spmc_addr_match(rx_byte, slave_address_q, smask_q);
    else
      rx_accept = rx_ninth && spmc_addr_match(rx_byte, slave_address_q, smask_q);
  end
  assign rx_evt = (rx_done & rx_accept) | m0_rx_evt;
  assign fe_evt = rx_done & ~rx_stop;

  // Transmitter and shift-mode engine
  assign tcnt_zero = (tcnt_q == 16'h0000);
  assign m0_byte = {rxd_in, tsh_q[7:1]};
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      tx_state_q <= TX_IDLE;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 9'h000;
      sh_rx_q <= 1'b0;
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
      tx_evt <= 1'b0;
      m0_rx_evt <= 1'b0;
    end
    else
    begin
      tx_evt <= 1'b0;
      m0_rx_evt <= 1'b0;
      if (!tcnt_zero)
        tcnt_q <= tcnt_q - 16'h0001;
      unique case (tx_state_q)
        TX_IDLE:
        begin
          txd <= 1'b1;
          rxd_oe_n <= 1'b1;
          tbit_q <= 4'h0;
          tcnt_q <= bit_cycles - 16'h0001;
          if (wr_lo && avs_address == SPMC_OFS_DATA)
          begin
            tsh_q <= {tb8_q, wbyte};
            sh_rx_q <= 1'b0;
            if (mode == SPMC_MODE_SHIFT)
            begin
              tx_state_q <= SH_RUN;
              rxd_out <= wbyte[0];
              rxd_oe_n <= 1'b0;
            end
            else
            begin
              tx_state_q <= TX_START;
              txd <= 1'b0;
            end
          end
          else if (mode == SPMC_MODE_SHIFT && ren_q && !ri_q)
          begin
            tx_state_q <= SH_RUN;
            sh_rx_q <= 1'b1;
          end
        end
        TX_START:
          if (tcnt_zero)
          begin
            txd <= tsh_q[0];
            tsh_q <= {1'b0, tsh_q[8:1]};
            tcnt_q <= bit_cycles - 16'h0001;
            tx_state_q <= TX_DATA;
          end
        TX_DATA:
          if (tcnt_zero)
          begin
            tcnt_q <= bit_cycles - 16'h0001;
            tbit_q <= tbit_q + 4'h1;
            if (tbit_q == (sm0_q ? 4'h8 : 4'h7))
            begin
              txd <= 1'b1;
              tx_evt <= 1'b1;
              tx_state_q <= TX_STOP;
            end
            else
            begin
              txd <= tsh_q[0];
              tsh_q <= {1'b0, tsh_q[8:1]};
            end
          end
        TX_STOP:
          if (tcnt_zero)
            tx_state_q <= TX_IDLE;
        SH_RUN:
        begin
          // Shift clock low for the first half of each bit
          txd <= (tcnt_q < {1'b0, bit_cycles[15:1]});
          if (tcnt_zero)
          begin
            tcnt_q <= bit_cycles - 16'h0001;
            tbit_q <= tbit_q + 4'h1;
            tsh_q <= sh_rx_q ? {1'b0, m0_byte} : {1'b0, tsh_q[8:1]};
            rxd_out <= tsh_q[1];
            if (tbit_q == 4'h7)
            begin
              tx_state_q <= TX_IDLE;
              tx_evt <= ~sh_rx_q;
              m0_rx_evt <= sh_rx_q;
              txd <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Received data and ninth bit
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rx_data_q <= SPMC_RST_BYTE;
      rb8_q <= 1'b0;
    end
    else if (m0_rx_evt)
      rx_data_q <= m0_byte;
    else if (rx_done && rx_accept)
    begin
      rx_data_q <= rx_byte;
      rb8_q <= sm0_q ? rx_ninth : rx_stop;
    end
    else if (wr_lo && avs_address == SPMC_OFS_CTRL)
      rb8_q <= wbyte[SPMC_B_RB8];
  end

  // Flags: hardware set wins over a software clear
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ti_q <= 1'b0;
      ri_q <= 1'b0;
      fe_q <= 1'b0;
    end
    else
    begin
      if (tx_evt)
        ti_q <= 1'b1;
      else if (wr_lo && avs_address == SPMC_OFS_CTRL)
        ti_q <= wbyte[SPMC_B_TI];
      if (rx_evt)
        ri_q <= 1'b1;
      else if (wr_lo && avs_address == SPMC_OFS_CTRL)
        ri_q <= wbyte[SPMC_B_RI];
      if (fe_evt)
        fe_q <= 1'b1;
      else if (wr_lo && avs_address == SPMC_OFS_CTRL && frame_error_select_q)
        fe_q <= wbyte[SPMC_B_SM0_FE];
    end
  end

  // Sticky event status, cleared by reading it
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_stat_q <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      // Only bits actually returned are cleared, so no event is lost
      irq_stat_q <= (irq_stat_q & ~((rd_acc && avs_address == SPMC_OFS_IRQ_STAT) ?
                     avs_readdata[2:0] : 3'h0)) | {fe_evt, tx_evt, rx_evt};
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule // spmc_top
`default_nettype wire

// ===== rtl/spmc_pkg.sv
// Constants, types and helpers shared by the serial port control block
`default_nettype none
package spmc_pkg;
  // Register byte offsets
  localparam logic [4:0] SPMC_OFS_CTRL = 5'h00;
  localparam logic [4:0] SPMC_OFS_CFG = 5'h04;
  localparam logic [4:0] SPMC_OFS_SLAVE_ADDRESS = 5'h08;
  localparam logic [4:0] SPMC_OFS_SMASK = 5'h0c;
  localparam logic [4:0] SPMC_OFS_DATA = 5'h10;
  localparam logic [4:0] SPMC_OFS_BAUD = 5'h14;
  localparam logic [4:0] SPMC_OFS_IRQ_STAT = 5'h18;
  localparam logic [4:0] SPMC_OFS_IRQ_MASK = 5'h1c;
  // Control register fields
  localparam int SPMC_B_SM0_FE = 7;
  localparam int SPMC_B_SM1 = 6;
  localparam int SPMC_B_SM2 = 5;
  localparam int SPMC_B_REN = 4;
  localparam int SPMC_B_TB8 = 3;
  localparam int SPMC_B_RB8 = 2;
  localparam int SPMC_B_TI = 1;
  localparam int SPMC_B_RI = 0;
  // Configuration register fields
  localparam int SPMC_B_BAUD_DOUBLE_SELECT = 7;
  localparam int SPMC_B_FRAME_ERROR_SELECT = 6;
  localparam int SPMC_B_TX_BUSY = 0;
  // Interrupt status / mask fields
  localparam int SPMC_B_IRQ_RX = 0;
  localparam int SPMC_B_IRQ_TX = 1;
  localparam int SPMC_B_IRQ_FE = 2;
  // Reset values
  localparam logic [7:0] SPMC_RST_BYTE = 8'h00;
  localparam logic [15:0] SPMC_RST_BAUD = 16'h00d8;
  // Bit periods in oscillator cycles
  localparam logic [15:0] SPMC_CYC_MODE0 = 16'h000c;
  localparam logic [15:0] SPMC_CYC_MODE2_SLOW = 16'h0040;
  localparam logic [15:0] SPMC_CYC_MODE2_FAST = 16'h0020;
  // Serial modes
  localparam logic [1:0] SPMC_MODE_SHIFT = 2'h0;
  localparam logic [1:0] SPMC_MODE_UART8 = 2'h1;
  localparam logic [1:0] SPMC_MODE_UART9_FIXED = 2'h2;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} spmc_rx_state_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP, SH_RUN} spmc_tx_state_t;

  // Given or broadcast address hit; zero mask bits are don't-care in the given form, zero bits in the broadcast form
  function automatic logic spmc_addr_match(input logic [7:0] rx, input logic [7:0] addr,
                                           input logic [7:0] mask);
    logic [7:0] given;
    logic [7:0] bcast;
    given = addr & mask;
    bcast = addr | mask;
    spmc_addr_match = (((rx ^ given) & mask) == 8'h00) || ((~rx & bcast) == 8'h00);
  endfunction
endpackage
`default_nettype wire

// ===== rtl/spmc_rx.sv
// Asynchronous frame receiver, mid-bit sampling
`default_nettype none
module spmc_rx
  import spmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic ninth_en,
  input wire logic [15:0] bit_cycles,
  // Line
  input wire logic rxd,
  // Result
  output logic done,
  output logic [7:0] data,
  output logic ninth,
  output logic stop_bit
);
  spmc_rx_state_t state_q;
  logic [15:0] cnt_q;
  logic [3:0] bitn_q;
  logic [8:0] sh_q;
  logic cnt_zero;

  assign cnt_zero = (cnt_q == 16'h0000);
  // 8-bit frames land in the upper bits of the shifter
  assign data = ninth_en ? sh_q[7:0] : sh_q[8:1];
  assign ninth = sh_q[8];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= RX_IDLE;
      cnt_q <= 16'h0000;
      bitn_q <= 4'h0;
      sh_q <= 9'h000;
      done <= 1'b0;
      stop_bit <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!cnt_zero)
        cnt_q <= cnt_q - 16'h0001;
      if (!enable)
        state_q <= RX_IDLE;
      else
      begin
        unique case (state_q)
          RX_IDLE:
            if (!rxd)
            begin
              cnt_q <= {1'b0, bit_cycles[15:1]};
              state_q <= RX_START;
            end
          RX_START:
            if (cnt_zero)
            begin
              // Glitch shorter than half a bit is not a start
              state_q <= rxd ? RX_IDLE : RX_DATA;
              cnt_q <= bit_cycles - 16'h0001;
              bitn_q <= 4'h0;
            end
          RX_DATA:
            if (cnt_zero)
            begin
              sh_q <= {rxd, sh_q[8:1]};
              cnt_q <= bit_cycles - 16'h0001;
              bitn_q <= bitn_q + 4'h1;
              if (bitn_q == (ninth_en ? 4'h8 : 4'h7))
                state_q <= RX_STOP;
            end
          RX_STOP:
            if (cnt_zero)
            begin
              done <= 1'b1;
              stop_bit <= rxd;
              state_q <= RX_IDLE;
            end
        endcase
      end
    end
  end
endmodule // spmc_rx
`default_nettype wire

// ===== testbench/spmc_monitor.sv
// Port assertions for the serial port control block
`default_nettype none
module spmc_monitor
  import spmc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt and pins
  input wire logic irq,
  input wire logic txd,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] fall_q;
  logic txd_q;

  // Shift clock falls while the data pin is driven
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fall_q <= 4'h0;
      txd_q <= 1'b1;
    end
    else
    begin
      txd_q <= txd;
      if (rxd_oe_n)
        fall_q <= 4'h0;
      else if (txd_q && !txd)
        fall_q <= fall_q + 4'h1;
    end
  end

  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait state");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_rdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("readdata moved between accesses");
  chk_rdata_upper: assert property (avs_read && !avs_waitrequest && avs_address != SPMC_OFS_BAUD
    |-> avs_readdata[31:8] == 24'h0)
    else $error("unused read bits set");
  chk_irq_masked: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address == SPMC_OFS_IRQ_MASK && avs_writedata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("irq high with mask clear");
  chk_shift_low: assert property ($fell(txd) && !rxd_oe_n |-> !txd [*6] ##1 txd)
    else $error("shift clock low phase wrong");
  chk_shift_count: assert property ($rose(rxd_oe_n) |-> fall_q == 4'h8 && txd)
    else $error("shift frame not eight bits");
endmodule // spmc_monitor
`default_nettype wire

// ===== testbench/spmc_remote_node.sv
// Remote serial node: frame sender and frame catcher
`default_nettype none
module spmc_remote_node
(
  // Clock
  input wire logic clk,
  // Line
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 64;
  int rx_bits = 9;
  logic cap_en = 1'b0;
  logic [9:0] got = 10'h000;
  int got_n = 0;

  initial rxd = 1'b1;

  // Start, data LSB first, stop, one idle bit
  task automatic send(input logic [8:0] v, input int nbits, input logic stop);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < nbits; i++)
    begin
      rxd <= v[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rxd <= stop;
    repeat (bit_cyc) @(posedge clk);
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge clk);
  endtask

  // Mid-bit sampling; off in shift mode where txd is a clock
  always
  begin
    @(negedge txd);
    if (cap_en)
    begin
      repeat (bit_cyc + bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < rx_bits; i++)
      begin
        got[i] = txd;
        repeat (bit_cyc) @(posedge clk);
      end
      got[rx_bits] = txd;
      got_n++;
    end
  end
endmodule // spmc_remote_node
`default_nettype wire

// ===== testbench/spmc_top_test.sv
// Self-checking bench for the serial port control block
`default_nettype none
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module spmc_top_test
  import spmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic txd, rxd_in, rxd_out, rxd_oe_n, node_rxd;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] rd;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] ctl[6] = '{8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'h70, 8'h70};
  logic [8:0] fr[6] = '{9'h0c0, 9'h1c1, 9'h1c2, 9'h1ff, 9'h0c1, 9'h0c2};
  int nb[6] = '{9, 9, 9, 9, 8, 8};
  logic [7:0] ex[6] = '{8'hf0, 8'hf0, 8'hf5, 8'hf5, 8'h70, 8'h75};

  // Shared data pin: the block wins while it drives
  assign rxd_in = rxd_oe_n ? node_rxd : rxd_out;

  spmc_top i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .txd(txd), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));
  spmc_remote_node i_node (.clk(sys_clk), .txd(txd), .rxd(node_rxd));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      final_report();
    end
  end

  // One access; held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic check(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask

  initial
  begin
    arst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(SPMC_OFS_CTRL, 8'h00);
    check(SPMC_OFS_SLAVE_ADDRESS, 8'h00);
    check(SPMC_OFS_SMASK, 8'h00);
    $display("test reset done");
    i_node.cap_en = 1'b1;
    bus(1'b1, SPMC_OFS_IRQ_MASK, 8'h05);
    bus(1'b1, SPMC_OFS_CTRL, 8'h88);
    bus(1'b1, SPMC_OFS_DATA, 8'ha5);
    wait (i_node.got_n == 1);
    `CHK(i_node.got, 10'h3a5)
    `CHK(irq, 1'b0)
    check(SPMC_OFS_CTRL, 8'h8a);
    bus(1'b1, SPMC_OFS_IRQ_MASK, 8'h07);
    repeat (2) @(negedge sys_clk);
    `CHK(irq, 1'b1)
    check(SPMC_OFS_IRQ_STAT, 8'h02);
    repeat (2) @(negedge sys_clk);
    `CHK(irq, 1'b0)
    bus(1'b1, SPMC_OFS_IRQ_MASK, 8'h00);
    $display("test nine bit transmit done");
    i_node.cap_en = 1'b0;
    i_node.bit_cyc = 217;
    bus(1'b1, SPMC_OFS_CTRL, 8'hc0);
    i_node.send(9'h13c, 9, 1'b1);
    check(SPMC_OFS_CTRL, 8'hc0);
    bus(1'b1, SPMC_OFS_CTRL, 8'hd0);
    i_node.send(9'h13c, 9, 1'b1);
    check(SPMC_OFS_CTRL, 8'hd5);
    check(SPMC_OFS_DATA, 8'h3c);
    $display("test receive done");
    bus(1'b1, SPMC_OFS_SLAVE_ADDRESS, 8'hc0);
    bus(1'b1, SPMC_OFS_SMASK, 8'hfd);
    foreach (fr[i])
    begin
      bus(1'b1, SPMC_OFS_CTRL, ctl[i]);
      i_node.send(fr[i], nb[i], 1'b1);
      check(SPMC_OFS_CTRL, ex[i]);
    end
    $display("test address filter done");
    bus(1'b1, SPMC_OFS_CFG, 8'hc0);
    bus(1'b1, SPMC_OFS_CTRL, 8'h50);
    // Low stop bit; the line is high again before a false start is confirmed
    i_node.send(9'h055, 8, 1'b0);
    check(SPMC_OFS_CTRL, 8'hd1);
    i_node.send(9'h155, 9, 1'b1);
    check(SPMC_OFS_CTRL, 8'hd5);
    bus(1'b1, SPMC_OFS_CTRL, 8'h52);
    check(SPMC_OFS_CTRL, 8'h52);
    bus(1'b1, SPMC_OFS_CTRL, 8'hd2);
    check(SPMC_OFS_CTRL, 8'hd2);
    bus(1'b1, SPMC_OFS_CFG, 8'h00);
    check(SPMC_OFS_CTRL, 8'h52);
    $display("test framing error done");
    bus(1'b1, SPMC_OFS_CTRL, 8'h00);
    bus(1'b1, SPMC_OFS_DATA, 8'h5a);
    repeat (8 * 12 + 24) @(posedge sys_clk);
    check(SPMC_OFS_CTRL, 8'h02);
    $display("test shift mode done");
    final_report();
  end
endmodule // spmc_top_test

bind spmc_top spmc_monitor i_mon (.sys_clk(sys_clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));
`default_nettype wire
